// ### rtl/nibble_cpu_regs.svh
/*
  Opcode patterns, field positions, reset values and port selectors of the nibble instruction decoder.
  Assumes inclusion by bare name from the decoder files only.
*/
`ifndef NIBBLE_CPU_REGS_SVH
`define NIBBLE_CPU_REGS_SVH

// ----------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------
`define NIB_W 4
`define H_W 2
`define ADDR_W 6
`define MEM_DEPTH 64
`define NIB_RESET 4'h0
`define H_RESET 2'h0
`define NIB_ALL_ONES 4'hF
`define NIB_ZERO 4'h0

// ----------------------------------------------------------------
// One-byte opcode patterns
// ----------------------------------------------------------------
`define OP_LOAD_ACC_IMM 8'b0001????
`define OP_LOAD_H_IMM 8'b001010??
`define OP_LOAD_ACC_FROM_POINTER 8'b010100??
`define OP_LOAD_PAIR_IMM 8'b110?????
`define OP_WRITE_ACC_TO_MEM 8'h57
`define OP_WRITE_IMM_ADVANCE 8'b0100????
`define OP_SWAP_ACC_LOW_REG 8'h7B
`define OP_SWAP_ACC_POINTER_MEM 8'b010101??
`define OP_ADD_IMM_SKIP_CARRY 8'b0000????
`define OP_ADD_MEM_NO_CARRY_IN 8'h7D
`define OP_ADD_MEM_WITH_CARRY 8'h7C
`define OP_XOR_ACC_MEM 8'h7E
`define OP_INCREMENT_L_SKIP 8'h59
`define OP_DECREMENT_L_SKIP 8'h58
`define OP_CLEAR_MEM_BIT 8'b011010??
`define OP_SET_MEM_BIT 8'b011011??
`define OP_READ_PORT_BY_L 8'h70
`define OP_WRITE_PORT_BY_L 8'h72
`define OP_SUBROUTINE_RETURN 8'h53

// ----------------------------------------------------------------
// Two-byte opcodes
// ----------------------------------------------------------------
`define OP_INCREMENT_MEM_DIRECT 8'h3D
`define OP_DECREMENT_MEM_DIRECT 8'h3C
`define OP_TWO_BYTE_JUMP 8'b001000??
`define OP_TWO_BYTE_CALL 8'b001100??
`define OP_TWO_BYTE_MISC 8'b001111??

// ----------------------------------------------------------------
// Pair addressing field
// ----------------------------------------------------------------
`define PR_DEC_AFTER 2'b00
`define PR_INC_AFTER 2'b01
`define PR_PLAIN 2'b10

// ----------------------------------------------------------------
// L selectors for port access
// ----------------------------------------------------------------
`define SEL_PORT0 4'h0
`define SEL_PORT1 4'h1
`define SEL_PORT8 4'h8
`define SEL_PORT9 4'h9
`define SEL_PORT10 4'hA
`define SEL_PORT11 4'hB
`define SEL_CLK_MODE 4'hC
`define SEL_PROBE_FLAG 4'hF
`define PROBE_BIT 3

`endif

// ### rtl/nibble_cpu_pkg.sv
/*
  Types shared by the nibble instruction decoder.
  Assumes nothing of its surroundings.
*/
package nibble_cpu_pkg;

  // Phase of a possibly two-byte instruction
  typedef enum logic {PH_FIRST, PH_SECOND} phase_type;

  // Kind of the last load used for run suppression
  typedef enum logic [1:0] {RUN_NONE, RUN_ACC, RUN_PAIR} run_kind_type;

endpackage : nibble_cpu_pkg

// ### rtl/nibble_adder.sv
/*
  Four-bit adder with carry in and carry out.
  Assumes purely combinational use by the decoder.
*/
module nibble_adder #(
  parameter int WIDTH = 4
) (
  input wire logic [WIDTH-1:0] a,
  input wire logic [WIDTH-1:0] b,
  input wire logic cin,
  output logic [WIDTH-1:0] sum,
  output logic cout
);

  // Full-width sum split into result and carry
  assign {cout, sum} = {1'b0, a} + {1'b0, b} + {{WIDTH{1'b0}}, cin};

endmodule : nibble_adder

// ### rtl/nibble_cpu_instruction_decode.sv
/*
  Decoder and executor for a subset of a 4-bit microcontroller instruction set,
  with accumulator, carry, H and L registers, 64 x 4 data memory and port latches.
  Assumes one instruction byte offered per valid cycle, synchronous to MCLK.

*/
`include "nibble_cpu_regs.svh"

module nibble_cpu_instruction_decode (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic INSTR_VALID,
  input wire logic [7:0] INSTR_BYTE,
  input wire logic [3:0] PORT0_IN,
  input wire logic [3:0] PORT1_IN,
  input wire logic [3:0] PORT10_IN,
  input wire logic [3:0] PORT11_IN,
  output logic [3:0] ACC,
  output logic [1:0] H_REG,
  output logic [3:0] L_REG,
  output logic CARRY,
  output logic SKIP_PENDING,
  output logic [3:0] PORT8_OUT,
  output logic [3:0] PORT9_OUT,
  output logic [3:0] PORT10_OUT,
  output logic [3:0] PORT11_OUT,
  output logic [3:0] CLK_MODE,
  output logic EXT_PROBE_ENABLE_FLAG
);
  import nibble_cpu_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [3:0] acc_q, acc_d;
  logic [1:0] h_q, h_d;
  logic [3:0] l_q, l_d;
  logic carry_q, carry_d;
  logic skip_q, skip_d;
  phase_type phase_q, phase_d;
  logic [7:0] first_q, first_d;
  logic drop_q, drop_d;
  run_kind_type run_q, run_d;
  logic [3:0] p8_q, p8_d, p9_q, p9_d, p10_q, p10_d, p11_q, p11_d;
  logic [3:0] clk_mode_q, clk_mode_d;
  logic probe_q, probe_d;
  logic [3:0] mem [`MEM_DEPTH];
  logic mem_we;
  logic [5:0] mem_waddr;
  logic [3:0] mem_wdata;

  // ----------------------------------------------------------------
  // Datapath helpers
  // ----------------------------------------------------------------
  logic [5:0] ptr_addr;
  logic [3:0] ptr_data;
  logic [3:0] dir_data;
  logic [3:0] add_b;
  logic add_cin;
  logic [3:0] add_sum;
  logic add_cout;
  run_kind_type byte_kind;
  logic two_byte;
  logic suppress;

  // Pointer and direct memory reads
  assign ptr_addr = {h_q, l_q};
  assign ptr_data = mem[ptr_addr];
  assign dir_data = mem[INSTR_BYTE[5:0]];

  // Adder operands: immediate for upper nibble 0000, else pointer memory
  assign add_b = (INSTR_BYTE[7:4] == 4'h0) ? INSTR_BYTE[3:0] : ptr_data;
  assign add_cin = (INSTR_BYTE == `OP_ADD_MEM_WITH_CARRY) ? carry_q : 1'b0;

  nibble_adder #(
    .WIDTH(`NIB_W)
  ) u_adder (
    .a(acc_q),
    .b(add_b),
    .cin(add_cin),
    .sum(add_sum),
    .cout(add_cout)
  );

  // Classify the byte for run suppression and length
  always_comb begin
    byte_kind = RUN_NONE;
    two_byte = 1'b0;
    casez (INSTR_BYTE)
      `OP_LOAD_ACC_IMM: byte_kind = RUN_ACC;
      `OP_LOAD_PAIR_IMM: byte_kind = RUN_PAIR;
      `OP_TWO_BYTE_JUMP, `OP_TWO_BYTE_CALL, `OP_TWO_BYTE_MISC: two_byte = 1'b1;
      default: byte_kind = RUN_NONE;
    endcase
  end

  // Pending skip or a repeated load in a run cancels the instruction
  assign suppress = skip_q || (byte_kind != RUN_NONE && byte_kind == run_q);

  // ----------------------------------------------------------------
  // Decode and execute
  // ----------------------------------------------------------------
  always_comb begin
    acc_d = acc_q;
    h_d = h_q;
    l_d = l_q;
    carry_d = carry_q;
    skip_d = skip_q;
    phase_d = phase_q;
    first_d = first_q;
    drop_d = drop_q;
    run_d = run_q;
    p8_d = p8_q;
    p9_d = p9_q;
    p10_d = p10_q;
    p11_d = p11_q;
    clk_mode_d = clk_mode_q;
    probe_d = probe_q;
    mem_we = 1'b0;
    mem_waddr = ptr_addr;
    mem_wdata = ptr_data;
    if (INSTR_VALID) begin
      case (phase_q)
        PH_FIRST: begin
          run_d = byte_kind;
          skip_d = 1'b0;
          if (two_byte) begin
            phase_d = PH_SECOND;
            first_d = INSTR_BYTE;
            drop_d = suppress;
          end else if (!suppress) begin
            casez (INSTR_BYTE)
              `OP_LOAD_ACC_IMM: acc_d = INSTR_BYTE[3:0];
              `OP_LOAD_H_IMM: h_d = INSTR_BYTE[1:0];
              `OP_LOAD_PAIR_IMM: begin
                h_d = {1'b0, INSTR_BYTE[4]};
                l_d = INSTR_BYTE[3:0];
              end
              `OP_WRITE_ACC_TO_MEM: begin
                mem_we = 1'b1;
                mem_wdata = acc_q;
              end
              `OP_SUBROUTINE_RETURN: acc_d = acc_q; // Return shares the load pattern, not handled here
              `OP_LOAD_ACC_FROM_POINTER, `OP_SWAP_ACC_POINTER_MEM: begin
                acc_d = ptr_data;
                if (INSTR_BYTE[2]) begin
                  mem_we = 1'b1;
                  mem_wdata = acc_q;
                end
                // Post-adjust of L by the pair field
                case (INSTR_BYTE[1:0])
                  `PR_DEC_AFTER: begin
                    l_d = l_q - 4'h1;
                    skip_d = (l_q == `NIB_ZERO);
                  end
                  `PR_INC_AFTER: begin
                    l_d = l_q + 4'h1;
                    skip_d = (l_q == `NIB_ALL_ONES);
                  end
                  default: l_d = l_q;
                endcase
              end
              `OP_WRITE_IMM_ADVANCE: begin
                mem_we = 1'b1;
                mem_wdata = INSTR_BYTE[3:0];
                l_d = l_q + 4'h1;
              end
              `OP_SWAP_ACC_LOW_REG: begin
                acc_d = l_q;
                l_d = acc_q;
              end
              `OP_ADD_IMM_SKIP_CARRY, `OP_ADD_MEM_NO_CARRY_IN: begin
                acc_d = add_sum;
                skip_d = add_cout;
              end
              `OP_ADD_MEM_WITH_CARRY: begin
                acc_d = add_sum;
                carry_d = add_cout;
                skip_d = add_cout;
              end
              `OP_XOR_ACC_MEM: acc_d = acc_q ^ ptr_data;
              `OP_INCREMENT_L_SKIP: begin
                l_d = l_q + 4'h1;
                skip_d = (l_q == `NIB_ALL_ONES);
              end
              `OP_DECREMENT_L_SKIP: begin
                l_d = l_q - 4'h1;
                skip_d = (l_q == `NIB_ZERO);
              end
              `OP_CLEAR_MEM_BIT: begin
                mem_we = 1'b1;
                mem_wdata = ptr_data & ~(4'h1 << INSTR_BYTE[1:0]);
              end
              `OP_SET_MEM_BIT: begin
                mem_we = 1'b1;
                mem_wdata = ptr_data | (4'h1 << INSTR_BYTE[1:0]);
              end
              `OP_READ_PORT_BY_L: begin
                // Unselected L values leave the accumulator alone
                case (l_q)
                  `SEL_PORT0: acc_d = PORT0_IN;
                  `SEL_PORT1: acc_d = PORT1_IN;
                  `SEL_PORT10: acc_d = PORT10_IN;
                  `SEL_PORT11: acc_d = PORT11_IN;
                  default: acc_d = acc_q;
                endcase
              end
              `OP_WRITE_PORT_BY_L: begin
                case (l_q)
                  `SEL_PORT8: p8_d = acc_q;
                  `SEL_PORT9: p9_d = acc_q;
                  `SEL_PORT10: p10_d = acc_q;
                  `SEL_PORT11: p11_d = acc_q;
                  `SEL_CLK_MODE: clk_mode_d = acc_q;
                  `SEL_PROBE_FLAG: probe_d = acc_q[`PROBE_BIT];
                  default: probe_d = probe_q;
                endcase
              end
              default: acc_d = acc_q;
            endcase
          end
        end
        PH_SECOND: begin
          phase_d = PH_FIRST;
          mem_waddr = INSTR_BYTE[5:0];
          if (!drop_q) begin
            if (first_q == `OP_INCREMENT_MEM_DIRECT) begin
              mem_we = 1'b1;
              mem_wdata = dir_data + 4'h1;
              skip_d = (dir_data == `NIB_ALL_ONES);
            end else if (first_q == `OP_DECREMENT_MEM_DIRECT) begin
              mem_we = 1'b1;
              mem_wdata = dir_data - 4'h1;
              skip_d = (dir_data == `NIB_ZERO);
            end
          end
        end
        default: phase_d = PH_FIRST;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Working registers
  always_ff @(posedge MCLK) begin
    if (RST) begin
      acc_q <= `NIB_RESET;
      h_q <= `H_RESET;
      l_q <= `NIB_RESET;
      carry_q <= 1'b0;
    end else begin
      acc_q <= acc_d;
      h_q <= h_d;
      l_q <= l_d;
      carry_q <= carry_d;
    end
  end

  // Sequencing, skip and run tracking
  always_ff @(posedge MCLK) begin
    if (RST) begin
      skip_q <= 1'b0;
      phase_q <= PH_FIRST;
      first_q <= 8'h00;
      drop_q <= 1'b0;
      run_q <= RUN_NONE;
    end else begin
      skip_q <= skip_d;
      phase_q <= phase_d;
      first_q <= first_d;
      drop_q <= drop_d;
      run_q <= run_d;
    end
  end

  // Output latches and mode flags
  always_ff @(posedge MCLK) begin
    if (RST) begin
      p8_q <= `NIB_RESET;
      p9_q <= `NIB_RESET;
      p10_q <= `NIB_RESET;
      p11_q <= `NIB_RESET;
      clk_mode_q <= `NIB_RESET;
      probe_q <= 1'b0;
    end else begin
      p8_q <= p8_d;
      p9_q <= p9_d;
      p10_q <= p10_d;
      p11_q <= p11_d;
      clk_mode_q <= clk_mode_d;
      probe_q <= probe_d;
    end
  end

  // Data memory keeps its contents through reset
  always_ff @(posedge MCLK) begin
    if (mem_we) begin
      mem[mem_waddr] <= mem_wdata;
    end
  end

  // Outputs straight from flip-flops
  assign ACC = acc_q;
  assign H_REG = h_q;
  assign L_REG = l_q;
  assign CARRY = carry_q;
  assign SKIP_PENDING = skip_q;
  assign PORT8_OUT = p8_q;
  assign PORT9_OUT = p9_q;
  assign PORT10_OUT = p10_q;
  assign PORT11_OUT = p11_q;
  assign CLK_MODE = clk_mode_q;
  assign EXT_PROBE_ENABLE_FLAG = probe_q;
endmodule : nibble_cpu_instruction_decode

// ### dv/nibble_cpu_decode_checker.sv
/*
  Port-level checks of the nibble instruction decoder.
  Assumes one clock MCLK and a synchronous active-high RST.
*/
module nibble_cpu_decode_checker (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic INSTR_VALID,
  input wire logic [7:0] INSTR_BYTE,
  input wire logic [3:0] PORT0_IN,
  input wire logic [3:0] PORT1_IN,
  input wire logic [3:0] PORT10_IN,
  input wire logic [3:0] PORT11_IN,
  input wire logic [3:0] ACC,
  input wire logic [1:0] H_REG,
  input wire logic [3:0] L_REG,
  input wire logic CARRY,
  input wire logic SKIP_PENDING,
  input wire logic [3:0] PORT8_OUT,
  input wire logic [3:0] PORT9_OUT,
  input wire logic [3:0] PORT10_OUT,
  input wire logic [3:0] PORT11_OUT,
  input wire logic [3:0] CLK_MODE,
  input wire logic EXT_PROBE_ENABLE_FLAG
);
  timeunit 1ns;
  timeprecision 1ps;
  logic second_q;
  logic [1:0] run_q;
  logic [1:0] kind;
  logic first_act;

  // Load kind of the offered byte and whether it executes
  assign kind = (INSTR_BYTE[7:4] == 4'h1) ? 2'd1 : (INSTR_BYTE[7:5] == 3'b110) ? 2'd2 : 2'd0;
  assign first_act = INSTR_VALID && !second_q && !SKIP_PENDING;

  // Second-byte phase of two-byte opcodes
  always_ff @(posedge MCLK) begin
    if (RST) second_q <= 1'b0;
    else if (INSTR_VALID) second_q <= !second_q && (INSTR_BYTE[7:2] inside {6'h08, 6'h0C, 6'h0F});
  end

  // Kind of the previous first byte
  always_ff @(posedge MCLK) begin
    if (RST) run_q <= 2'd0;
    else if (INSTR_VALID && !second_q) run_q <= kind;
  end

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);

  acc_load_a: assert property (first_act && kind == 2'd1 && run_q != 2'd1 |=> ACC == $past(INSTR_BYTE[3:0]))
    else $error("accumulator load wrong");
  run_hold_a: assert property (first_act && kind == 2'd1 && run_q == 2'd1 |=> $stable(ACC) && !SKIP_PENDING)
    else $error("repeated load not suppressed");
  h_load_a: assert property (first_act && INSTR_BYTE[7:2] == 6'h0A |=> H_REG == $past(INSTR_BYTE[1:0]))
    else $error("H load wrong");
  pair_load_a: assert property (first_act && kind == 2'd2 && run_q != 2'd2 |=>
    {H_REG, L_REG} == {1'b0, $past(INSTR_BYTE[4:0])})
    else $error("pair load wrong");
  low_swap_a: assert property (first_act && INSTR_BYTE == 8'h7B |=>
    ACC == $past(L_REG) && L_REG == $past(ACC))
    else $error("accumulator and L swap wrong");
  imm_add_a: assert property (first_act && INSTR_BYTE[7:4] == 4'h0 |=>
    {SKIP_PENDING, ACC} == {1'b0, $past(ACC)} + {1'b0, $past(INSTR_BYTE[3:0])} && $stable(CARRY))
    else $error("immediate add wrong");
  skip_drop_a: assert property (INSTR_VALID && !second_q && SKIP_PENDING |=>
    !SKIP_PENDING && $stable(ACC) && $stable(L_REG) && $stable(H_REG) && $stable(CARRY))
    else $error("skipped instruction had an effect");
  ptr_inc_a: assert property (first_act && INSTR_BYTE[7:3] == 5'h0A && INSTR_BYTE[1:0] == 2'b01 |=>
    L_REG == $past(L_REG) + 4'h1 && SKIP_PENDING == (L_REG == 4'h0))
    else $error("pointer increment or skip wrong");
  ptr_dec_a: assert property (first_act && INSTR_BYTE[7:3] == 5'h0A && INSTR_BYTE[1:0] == 2'b00 |=>
    L_REG == $past(L_REG) - 4'h1 && SKIP_PENDING == (L_REG == 4'hF))
    else $error("pointer decrement or skip wrong");
  l_incr_a: assert property (first_act && INSTR_BYTE == 8'h59 |=>
    L_REG == $past(L_REG) + 4'h1 ##0 SKIP_PENDING == (L_REG == 4'h0))
    else $error("L increment wrong");
  l_decr_a: assert property (first_act && INSTR_BYTE == 8'h58 |=>
    L_REG == $past(L_REG) - 4'h1 ##0 SKIP_PENDING == (L_REG == 4'hF))
    else $error("L decrement wrong");
  imm_store_a: assert property (first_act && INSTR_BYTE[7:4] == 4'h4 |=> L_REG == $past(L_REG) + 4'h1 && !SKIP_PENDING)
    else $error("store immediate advance wrong");
endmodule : nibble_cpu_decode_checker

bind nibble_cpu_instruction_decode nibble_cpu_decode_checker i_nibble_cpu_decode_checker (.MCLK, .RST, .INSTR_VALID,
  .INSTR_BYTE, .PORT0_IN, .PORT1_IN, .PORT10_IN, .PORT11_IN, .ACC, .H_REG, .L_REG, .CARRY, .SKIP_PENDING,
  .PORT8_OUT, .PORT9_OUT, .PORT10_OUT, .PORT11_OUT, .CLK_MODE, .EXT_PROBE_ENABLE_FLAG);

// ### dv/nibble_cpu_instruction_decode_tb_top.sv
/*
  Self-checking bench of the nibble instruction decoder with a bench-side model.
  Assumes the decoder and its bound checker are compiled first.
*/
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin failures++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end

module nibble_cpu_instruction_decode_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic MCLK = 1'b0;
  logic RST = 1'b1;
  logic INSTR_VALID = 1'b0;
  logic [7:0] INSTR_BYTE = 8'h00;
  logic [3:0] PORT0_IN = 4'h0, PORT1_IN = 4'h0, PORT10_IN = 4'h0, PORT11_IN = 4'h0;
  logic [3:0] ACC, L_REG, PORT8_OUT, PORT9_OUT, PORT10_OUT, PORT11_OUT, CLK_MODE;
  logic [1:0] H_REG;
  logic CARRY, SKIP_PENDING, EXT_PROBE_ENABLE_FLAG;
  int failures = 0;
  int samples_checked = 0;
  int seed = 66;
  logic [3:0] m_acc = 4'h0, m_l = 4'h0, m_p8 = 4'h0, m_p9 = 4'h0, m_p10 = 4'h0, m_p11 = 4'h0, m_cm = 4'h0;
  logic [1:0] m_h = 2'h0, m_run = 2'h0;
  logic m_c = 1'b0, m_skip = 1'b0, m_fl = 1'b0, m_second = 1'b0, m_drop = 1'b0;
  logic [7:0] m_first = 8'h00;
  logic [3:0] m_mem [64];
  logic [7:0] dir_q [$] = '{8'h15, 8'h0C, 8'h1F, 8'h11, 8'h12, 8'hC5, 8'hC6, 8'hD7, 8'h57, 8'h6B, 8'h50, 8'h68,
    8'h54, 8'h7E, 8'h7D, 8'h7C, 8'h7C, 8'hCF, 8'h59, 8'hC0, 8'h58, 8'h3D, 8'h05, 8'h3C, 8'h05, 8'h3C, 8'h3F,
    8'h0F, 8'h3D, 8'h07, 8'h20, 8'h55, 8'h53, 8'h51, 8'hF0};

  nibble_cpu_instruction_decode i_nibble_cpu_instruction_decode (.MCLK, .RST, .INSTR_VALID, .INSTR_BYTE,
    .PORT0_IN, .PORT1_IN, .PORT10_IN, .PORT11_IN, .ACC, .H_REG, .L_REG, .CARRY, .SKIP_PENDING,
    .PORT8_OUT, .PORT9_OUT, .PORT10_OUT, .PORT11_OUT, .CLK_MODE, .EXT_PROBE_ENABLE_FLAG);

  // 100 MHz clock
  initial forever #5 MCLK = ~MCLK;

  // --------------------------------
  // Reference model of one taken byte
  // --------------------------------
  function automatic void model(input logic [7:0] b);
    logic [4:0] s;
    logic [3:0] t;
    logic [5:0] p;
    logic [1:0] k;
    logic sk;
    sk = 1'b0;
    p = {m_h, m_l};
    k = (b[7:4] == 4'h1) ? 2'd1 : (b[7:5] == 3'b110) ? 2'd2 : 2'd0;
    if (m_second) begin
      m_second = 1'b0;
      if (!m_drop && m_first[7:1] == 7'h1E) begin
        t = m_first[0] ? m_mem[b[5:0]] + 4'h1 : m_mem[b[5:0]] - 4'h1;
        m_mem[b[5:0]] = t;
        sk = (t == {4{~m_first[0]}});
      end
      m_skip = sk;
    end else begin
      m_first = b;
      m_drop = m_skip;
      m_second = b[7:2] inside {6'h08, 6'h0C, 6'h0F};
      if (!m_skip && !(k != 2'd0 && k == m_run)) begin
        casez (b)
          8'h57: m_mem[p] = m_acc;
          8'h53: ; // Return opcode, not handled by this block
          8'b0001????: m_acc = b[3:0];
          8'b001010??: m_h = b[1:0];
          8'b110?????: {m_h, m_l} = {1'b0, b[4:0]};
          8'b01010???, 8'b0101100?: begin
            t = m_mem[p];
            if (!b[3] && b[2]) m_mem[p] = m_acc;
            if (!b[3]) m_acc = t;
            if (!b[1]) begin
              m_l = b[0] ? m_l + 4'h1 : m_l - 4'h1;
              sk = (m_l == {4{~b[0]}});
            end
          end
          8'b0100????: begin
            m_mem[p] = b[3:0];
            m_l = m_l + 4'h1;
          end
          8'h7B: {m_acc, m_l} = {m_l, m_acc};
          8'b0000????, 8'b0111110?: begin
            t = b[7] | b[6] ? m_mem[p] : b[3:0];
            s = {1'b0, m_acc} + {1'b0, t} + {4'h0, m_c & b[6] & ~b[0]};
            m_acc = s[3:0];
            sk = s[4];
            if (b[6] && !b[0]) m_c = s[4];
          end
          8'h7E: m_acc = m_acc ^ m_mem[p];
          8'b01101???: m_mem[p][b[1:0]] = b[2];
          8'h70: case (m_l)
            4'h0: m_acc = PORT0_IN;
            4'h1: m_acc = PORT1_IN;
            4'hA: m_acc = PORT10_IN;
            4'hB: m_acc = PORT11_IN;
            default: ;
          endcase
          8'h72: case (m_l)
            4'h8: m_p8 = m_acc;
            4'h9: m_p9 = m_acc;
            4'hA: m_p10 = m_acc;
            4'hB: m_p11 = m_acc;
            4'hC: m_cm = m_acc;
            4'hF: m_fl = m_acc[3];
            default: ;
          endcase
          default: ;
        endcase
      end
      m_run = k;
      m_skip = sk;
    end
  endfunction : model

  // Compare every output with the model
  task automatic check_all();
    `CHK("acc", m_acc, ACC)
    `CHK("h", m_h, H_REG)
    `CHK("l", m_l, L_REG)
    `CHK("carry", m_c, CARRY)
    `CHK("skip", m_skip, SKIP_PENDING)
    `CHK("port8", m_p8, PORT8_OUT)
    `CHK("port9", m_p9, PORT9_OUT)
    `CHK("port10", m_p10, PORT10_OUT)
    `CHK("port11", m_p11, PORT11_OUT)
    `CHK("clk_mode", m_cm, CLK_MODE)
    `CHK("probe_flag", m_fl, EXT_PROBE_ENABLE_FLAG)
  endtask : check_all

  // Offer one byte just after an edge, then compare after the taking edge
  task automatic issue(input logic [7:0] b, input logic v = 1'b1);
    if (m_second) b[7:6] = 2'b00;
    INSTR_VALID = v;
    INSTR_BYTE = b;
    {PORT0_IN, PORT1_IN, PORT10_IN, PORT11_IN} = 16'($random(seed));
    if (v) model(b);
    @(posedge MCLK);
    #1;
    check_all();
  endtask : issue

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize

  // Main sequence: reset, fill memory, corner cases, ports, random stream
  initial begin
    repeat (16) @(posedge MCLK);
    #1;
    RST = 1'b0;
    check_all();
    issue(8'hC0);
    for (int h = 0; h < 4; h++) begin
      issue(8'h28 | 8'(h));
      repeat (16) issue(8'h40 | 8'($random(seed) & 15));
    end
    foreach (dir_q[i]) issue(dir_q[i]);
    for (int l = 0; l < 16; l++) begin
      issue(8'hC0 | 8'(l));
      issue(8'h70);
      issue(8'h10 | 8'($random(seed) & 15));
      issue(8'h72);
    end
    repeat (3000) issue(8'($random(seed)), ($random(seed) % 5) != 0);
    summarize();
  end

  // Watchdog: about six times the expected run length
  initial begin
    #200_000;
    failures++;
    summarize();
  end
endmodule : nibble_cpu_instruction_decode_tb_top
